//--- include/clock_output_control_map.vh
// Purpose: register offsets, field positions, reset values and counts of the clock output control
// Assumes: 32-bit AXI4-Lite data, one aligned word per register
// Notes: included by its bare name
// Behaviour
// R01: reference select low takes reference pair one, high takes pair two.
// R02: gated bank passes clock while gate input high, holds constant level when low.
// R03: gate changes never produce a shortened or partial pulse at outputs.
// R04: each output enable mode: always on, always off, by first, by second enable.
// R05: global tristate input high puts every clock output into high impedance.
// R06: global tristate high also disables feedback, so lock is lost and indicated.
// R07: two profile select inputs pick one of four stored configuration profiles.
// R08: bypass low drives output dividers from the oscillator, running as a loop.
// R09: bypass high drives output dividers straight from the input divider.
// R10: reset input high clears all counters and treats the loop as unlocked.
// R11: lock indicator is low when locked and high otherwise.
// R12: each bank selects which of five output dividers feeds its clock.
// R13: gating is enabled per bank; ungated banks ignore the gate input.
// R14: gate changes are taken per bank only while its clock sits low.
`ifndef CLOCK_OUTPUT_CONTROL_MAP_VH
`define CLOCK_OUTPUT_CONTROL_MAP_VH

// ****************************************************************
// register offsets
// ****************************************************************
`define COC_STATUS_OFS 12'h000
`define COC_IRQ_STATUS_OFS 12'h004
`define COC_IRQ_MASK_OFS 12'h008
`define COC_VCO_HALF_OFS 12'h00C
`define COC_IN_DIV_OFS 12'h010
`define COC_OUT_DIV_BASE 12'h020
`define COC_PROFILE_BASE 4'h1

// ****************************************************************
// field positions
// ****************************************************************
`define COC_ST_LOCK 0
`define COC_ST_REF 1
`define COC_ST_PROF_LO 2
`define COC_ST_BYPASS 4
`define COC_IRQ_GAINED 0
`define COC_IRQ_LOST 1
`define COC_CFG_DIV_HI 2
`define COC_CFG_GATE 3
`define COC_CFG_OEA_LO 4
`define COC_CFG_OEB_LO 6

// ****************************************************************
// enable modes and responses
// ****************************************************************
`define COC_OE_ON 2'h0
`define COC_OE_OFF 2'h1
`define COC_OE_FIRST 2'h2
`define COC_OE_SECOND 2'h3
`define COC_RESP_OKAY 2'h0
`define COC_RESP_SLVERR 2'h2

// ****************************************************************
// reset values and counts
// ****************************************************************
`define COC_CFG_RESET 8'h00
`define COC_VCO_HALF_RESET 8'h02
`define COC_IN_DIV_RESET 5'h00
`define COC_OUT_DIV_RESET 5'h01
`define COC_LOCK_TICKS 16
`define COC_REF_TIMEOUT_CYCLES 1024

`endif

//--- hdl/output_divider.v
// Purpose: programmable divider of a stream of source ticks
// Assumes: i_tick is a one-cycle enable on the core clock
// Notes: output level toggles every ratio+1 source ticks
`timescale 1ns/10ps
module output_divider #(
  parameter WIDTH = 5
) (
  // clock and reset
  input wire i_core_clk,
  input wire i_reset,
  input wire i_clear,
  // source and ratio
  input wire i_tick,
  input wire [WIDTH-1:0] i_ratio,
  // divided result
  output reg o_tick,
  output reg o_level
);

reg [WIDTH-1:0] count_reg;

always @(posedge i_core_clk)
begin
  if (i_reset || i_clear)
  begin
    count_reg <= {WIDTH{1'b0}}; // R10
    o_tick <= 1'b0;
    o_level <= 1'b0;
  end
  else
  begin
    o_tick <= 1'b0;
    if (i_tick)
    begin
      if (count_reg >= i_ratio)
      begin
        count_reg <= {WIDTH{1'b0}};
        o_tick <= 1'b1;
        o_level <= ~o_level;
      end
      else
      begin
        count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end
end

endmodule // output_divider

//--- hdl/clock_output_control.v
// Purpose: control logic of a clock generator and fan-out buffer with AXI4-Lite registers
// Assumes: all pins are asynchronous to i_core_clk; one clock, synchronous reset
// Notes: the oscillator is modelled as a programmable tick on the core clock
//
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/10ps
`include "clock_output_control_map.vh"
module clock_output_control #(
  parameter NUM_BANKS = 10,
  parameter LOCK_TICKS = `COC_LOCK_TICKS,
  parameter REF_TIMEOUT = `COC_REF_TIMEOUT_CYCLES
) (
  // clock and reset
  input wire i_core_clk,
  input wire i_reset,
  // reference and control pins
  input wire i_ref_pair_first,
  input wire i_ref_pair_second,
  input wire i_ref_pair_select,
  input wire i_sync_gate_in,
  input wire i_out_en_first,
  input wire i_out_en_second,
  input wire i_global_tristate_in,
  input wire i_profile_sel_lsb,
  input wire i_profile_sel_msb,
  input wire i_pll_bypass,
  input wire i_counter_reset,
  // bank outputs
  output reg [NUM_BANKS-1:0] o_bank_a,
  output reg [NUM_BANKS-1:0] o_bank_a_oe,
  output reg [NUM_BANKS-1:0] o_bank_b,
  output reg [NUM_BANKS-1:0] o_bank_b_oe,
  // status
  output reg o_lock_n,
  output reg o_irq,
  // axi4-lite write
  input wire [11:0] i_s_axi_awaddr,
  input wire i_s_axi_awvalid,
  output reg o_s_axi_awready,
  input wire [31:0] i_s_axi_wdata,
  input wire [3:0] i_s_axi_wstrb,
  input wire i_s_axi_wvalid,
  output reg o_s_axi_wready,
  output reg [1:0] o_s_axi_bresp,
  output reg o_s_axi_bvalid,
  input wire i_s_axi_bready,
  // axi4-lite read
  input wire [11:0] i_s_axi_araddr,
  input wire i_s_axi_arvalid,
  output reg o_s_axi_arready,
  output reg [31:0] o_s_axi_rdata,
  output reg [1:0] o_s_axi_rresp,
  output reg o_s_axi_rvalid,
  input wire i_s_axi_rready
);

// ****************************************************************
// pin synchroniser
// ****************************************************************
localparam NUM_PINS = 11;
wire [NUM_PINS-1:0] pin_raw;
reg [NUM_PINS-1:0] pin_meta_reg;
reg [NUM_PINS-1:0] pin_sync_reg;

assign pin_raw = {i_counter_reset, i_pll_bypass, i_profile_sel_msb, i_profile_sel_lsb,
  i_global_tristate_in, i_out_en_second, i_out_en_first, i_sync_gate_in,
  i_ref_pair_select, i_ref_pair_second, i_ref_pair_first};

always @(posedge i_core_clk)
begin
  if (i_reset)
  begin
    pin_meta_reg <= {NUM_PINS{1'b0}};
    pin_sync_reg <= {NUM_PINS{1'b0}};
  end
  else
  begin
    pin_meta_reg <= pin_raw;
    pin_sync_reg <= pin_meta_reg;
  end
end

wire ref_first = pin_sync_reg[0];
wire ref_second = pin_sync_reg[1];
wire ref_sel = pin_sync_reg[2];
wire gate_in = pin_sync_reg[3];
wire en_first = pin_sync_reg[4];
wire en_second = pin_sync_reg[5];
wire tristate = pin_sync_reg[6];
wire [1:0] profile = pin_sync_reg[8:7]; // R07
wire bypass = pin_sync_reg[9];
wire counter_clear = pin_sync_reg[10];

// ****************************************************************
// registers held by software
// ****************************************************************
reg [7:0] cfg_mem [0:63];
reg [7:0] vco_half_reg;
reg [4:0] in_div_reg;
reg [4:0] out_div_reg [0:4];
reg [1:0] irq_status_reg;
reg [1:0] irq_mask_reg;

// ****************************************************************
// reference selection, input divider and oscillator
// ****************************************************************
wire ref_now = ref_sel ? ref_second : ref_first; // R01
reg ref_prev_reg;
wire ref_rise = ref_now & ~ref_prev_reg;
wire in_tick;
reg [7:0] vco_cnt_reg;
wire vco_tick = (vco_cnt_reg >= vco_half_reg);

always @(posedge i_core_clk)
begin
  if (i_reset || counter_clear)
  begin
    ref_prev_reg <= 1'b0; // R10
    vco_cnt_reg <= 8'h00;
  end
  else
  begin
    ref_prev_reg <= ref_now;
    vco_cnt_reg <= vco_tick ? 8'h00 : vco_cnt_reg + 8'h01;
  end
end

output_divider #(.WIDTH(5)) in_divider (
  .i_core_clk(i_core_clk),
  .i_reset(i_reset),
  .i_clear(counter_clear),
  .i_tick(ref_rise),
  .i_ratio(in_div_reg),
  .o_tick(in_tick),
  .o_level()
);

// ****************************************************************
// output dividers
// ****************************************************************
wire src_tick = bypass ? in_tick : vco_tick; // R08 R09
wire [4:0] div_level;

genvar v;
generate
  for (v = 0; v < 5; v = v + 1)
  begin : gen_div
    output_divider #(.WIDTH(5)) out_divider (
      .i_core_clk(i_core_clk),
      .i_reset(i_reset),
      .i_clear(counter_clear),
      .i_tick(src_tick),
      .i_ratio(out_div_reg[v]),
      .o_tick(),
      .o_level(div_level[v])
    );
  end
endgenerate

// ****************************************************************
// lock detection
// ****************************************************************
reg [15:0] lock_cnt_reg;
reg [15:0] watch_reg;
reg locked_reg;
wire loop_ok = ~tristate & ~bypass & ~counter_clear; // R06
wire lock_next = loop_ok && (lock_cnt_reg >= LOCK_TICKS[15:0]);

always @(posedge i_core_clk)
begin
  if (i_reset || !loop_ok)
  begin
    lock_cnt_reg <= 16'h0000; // R10
    watch_reg <= 16'h0000;
    locked_reg <= 1'b0;
  end
  else
  begin
    locked_reg <= lock_next;
    if (in_tick)
    begin
      watch_reg <= 16'h0000;
      if (lock_cnt_reg < LOCK_TICKS[15:0])
        lock_cnt_reg <= lock_cnt_reg + 16'h0001;
    end
    else if (watch_reg >= REF_TIMEOUT[15:0])
    begin
      watch_reg <= 16'h0000;
      lock_cnt_reg <= 16'h0000;
    end
    else
    begin
      watch_reg <= watch_reg + 16'h0001;
    end
  end
end

// ****************************************************************
// banks: divider choice, gating and enables
// ****************************************************************
wire [NUM_BANKS-1:0] bank_clk;
wire [NUM_BANKS-1:0] bank_oe_a;
wire [NUM_BANKS-1:0] bank_oe_b;
wire [NUM_BANKS-1:0] gate_on_next;
reg [NUM_BANKS-1:0] gate_on_reg;

function oe_mode;
  input [1:0] mode;
  input first;
  input second;
  begin
    case (mode)
      `COC_OE_ON: oe_mode = 1'b1;
      `COC_OE_OFF: oe_mode = 1'b0;
      `COC_OE_FIRST: oe_mode = first;
      default: oe_mode = second;
    endcase
  end
endfunction

genvar b;
generate
  for (b = 0; b < NUM_BANKS; b = b + 1)
  begin : gen_bank
    localparam integer BANK_IDX = b;
    wire [7:0] cfg = cfg_mem[{profile, BANK_IDX[3:0]}]; // R07
    wire [2:0] sel = cfg[`COC_CFG_DIV_HI:0];
    wire lvl = (sel < 3'h5) ? div_level[sel] : div_level[0]; // R12
    assign gate_on_next[b] = lvl ? gate_on_reg[b] : gate_in; // R03 R14
    assign bank_clk[b] = cfg[`COC_CFG_GATE] ? (lvl & gate_on_reg[b]) : lvl; // R02 R13
    assign bank_oe_a[b] = ~tristate &
      oe_mode(cfg[`COC_CFG_OEA_LO+1:`COC_CFG_OEA_LO], en_first, en_second); // R04 R05
    assign bank_oe_b[b] = ~tristate &
      oe_mode(cfg[`COC_CFG_OEB_LO+1:`COC_CFG_OEB_LO], en_first, en_second); // R04 R05
  end
endgenerate

always @(posedge i_core_clk)
begin
  if (i_reset || counter_clear)
  begin
    gate_on_reg <= {NUM_BANKS{1'b0}};
    o_bank_a <= {NUM_BANKS{1'b0}};
    o_bank_b <= {NUM_BANKS{1'b0}};
    o_bank_a_oe <= {NUM_BANKS{1'b0}};
    o_bank_b_oe <= {NUM_BANKS{1'b0}};
  end
  else
  begin
    gate_on_reg <= gate_on_next;
    o_bank_a <= bank_clk;
    o_bank_b <= bank_clk;
    o_bank_a_oe <= bank_oe_a;
    o_bank_b_oe <= bank_oe_b;
  end
end

// ****************************************************************
// interrupts and lock pin
// ****************************************************************
reg lock_prev_reg;
wire [1:0] irq_event = {lock_prev_reg & ~locked_reg, ~lock_prev_reg & locked_reg};
reg [1:0] irq_clear;
wire [1:0] irq_status_next = (irq_status_reg & ~irq_clear) | irq_event;

always @(posedge i_core_clk)
begin
  if (i_reset)
  begin
    lock_prev_reg <= 1'b0;
    irq_status_reg <= 2'h0;
    o_irq <= 1'b0;
    o_lock_n <= 1'b1;
  end
  else
  begin
    lock_prev_reg <= locked_reg;
    irq_status_reg <= irq_status_next;
    o_irq <= |(irq_status_next & irq_mask_reg);
    o_lock_n <= ~locked_reg; // R11
  end
end

// ****************************************************************
// axi4-lite write channel
// ****************************************************************
reg [11:0] aw_addr_reg;
reg aw_full_reg;
reg [31:0] w_data_reg;
reg [3:0] w_strb_reg;
reg w_full_reg;
wire do_write = aw_full_reg & w_full_reg & ~o_s_axi_bvalid;
wire cfg_hit = (aw_addr_reg[11:8] == `COC_PROFILE_BASE) && (aw_addr_reg[1:0] == 2'h0) &&
  (aw_addr_reg[5:2] < NUM_BANKS);
wire div_hit = (aw_addr_reg[11:5] == `COC_OUT_DIV_BASE >> 5) && (aw_addr_reg[1:0] == 2'h0) &&
  (aw_addr_reg[4:2] < 3'h5);
wire reg_hit = (aw_addr_reg == `COC_STATUS_OFS) || (aw_addr_reg == `COC_IRQ_STATUS_OFS) ||
  (aw_addr_reg == `COC_IRQ_MASK_OFS) || (aw_addr_reg == `COC_VCO_HALF_OFS) ||
  (aw_addr_reg == `COC_IN_DIV_OFS);
wire wr_lane = do_write & w_strb_reg[0];
integer k;

always @*
begin
  irq_clear = 2'h0;
  if (wr_lane && (aw_addr_reg == `COC_IRQ_STATUS_OFS))
    irq_clear = w_data_reg[1:0];
end

always @(posedge i_core_clk)
begin
  if (i_reset)
  begin
    o_s_axi_awready <= 1'b1;
    o_s_axi_wready <= 1'b1;
    o_s_axi_bvalid <= 1'b0;
    o_s_axi_bresp <= `COC_RESP_OKAY;
    aw_full_reg <= 1'b0;
    w_full_reg <= 1'b0;
    aw_addr_reg <= 12'h000;
    w_data_reg <= 32'h00000000;
    w_strb_reg <= 4'h0;
    irq_mask_reg <= 2'h0;
    vco_half_reg <= `COC_VCO_HALF_RESET;
    in_div_reg <= `COC_IN_DIV_RESET;
    for (k = 0; k < 5; k = k + 1)
      out_div_reg[k] <= `COC_OUT_DIV_RESET;
    for (k = 0; k < 64; k = k + 1)
      cfg_mem[k] <= `COC_CFG_RESET;
  end
  else
  begin
    if (i_s_axi_awvalid && o_s_axi_awready)
    begin
      aw_addr_reg <= i_s_axi_awaddr;
      aw_full_reg <= 1'b1;
      o_s_axi_awready <= 1'b0;
    end
    if (i_s_axi_wvalid && o_s_axi_wready)
    begin
      w_data_reg <= i_s_axi_wdata;
      w_strb_reg <= i_s_axi_wstrb;
      w_full_reg <= 1'b1;
      o_s_axi_wready <= 1'b0;
    end
    if (do_write)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      o_s_axi_bvalid <= 1'b1;
      o_s_axi_bresp <= (cfg_hit || div_hit || reg_hit) ? `COC_RESP_OKAY : `COC_RESP_SLVERR;
    end
    if (o_s_axi_bvalid && i_s_axi_bready)
    begin
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_awready <= 1'b1;
      o_s_axi_wready <= 1'b1;
    end
    if (wr_lane)
    begin
      if (aw_addr_reg == `COC_IRQ_MASK_OFS)
        irq_mask_reg <= w_data_reg[1:0];
      else if (aw_addr_reg == `COC_VCO_HALF_OFS)
        vco_half_reg <= w_data_reg[7:0];
      else if (aw_addr_reg == `COC_IN_DIV_OFS)
        in_div_reg <= w_data_reg[4:0];
      else if (div_hit)
        out_div_reg[aw_addr_reg[4:2]] <= w_data_reg[4:0];
      else if (cfg_hit)
        cfg_mem[aw_addr_reg[7:2]] <= w_data_reg[7:0];
    end
  end
end

// ****************************************************************
// axi4-lite read channel
// ****************************************************************
reg [31:0] rd_data;
reg rd_ok;

always @*
begin
  rd_data = 32'h00000000;
  rd_ok = 1'b1;
  if (i_s_axi_araddr == `COC_STATUS_OFS)
    rd_data[4:0] = {bypass, profile, ref_sel, locked_reg};
  else if (i_s_axi_araddr == `COC_IRQ_STATUS_OFS)
    rd_data[1:0] = irq_status_reg;
  else if (i_s_axi_araddr == `COC_IRQ_MASK_OFS)
    rd_data[1:0] = irq_mask_reg;
  else if (i_s_axi_araddr == `COC_VCO_HALF_OFS)
    rd_data[7:0] = vco_half_reg;
  else if (i_s_axi_araddr == `COC_IN_DIV_OFS)
    rd_data[4:0] = in_div_reg;
  else if ((i_s_axi_araddr[11:5] == `COC_OUT_DIV_BASE >> 5) && (i_s_axi_araddr[1:0] == 2'h0) &&
    (i_s_axi_araddr[4:2] < 3'h5))
    rd_data[4:0] = out_div_reg[i_s_axi_araddr[4:2]];
  else if ((i_s_axi_araddr[11:8] == `COC_PROFILE_BASE) && (i_s_axi_araddr[1:0] == 2'h0) &&
    (i_s_axi_araddr[5:2] < NUM_BANKS))
    rd_data[7:0] = cfg_mem[i_s_axi_araddr[7:2]];
  else
    rd_ok = 1'b0;
end

always @(posedge i_core_clk)
begin
  if (i_reset)
  begin
    o_s_axi_arready <= 1'b1;
    o_s_axi_rvalid <= 1'b0;
    o_s_axi_rdata <= 32'h00000000;
    o_s_axi_rresp <= `COC_RESP_OKAY;
  end
  else if (i_s_axi_arvalid && o_s_axi_arready)
  begin
    o_s_axi_arready <= 1'b0;
    o_s_axi_rvalid <= 1'b1;
    o_s_axi_rdata <= rd_data;
    o_s_axi_rresp <= rd_ok ? `COC_RESP_OKAY : `COC_RESP_SLVERR;
  end
  else if (o_s_axi_rvalid && i_s_axi_rready)
  begin
    o_s_axi_rvalid <= 1'b0;
    o_s_axi_arready <= 1'b1;
  end
end

endmodule // clock_output_control

//--- verification/ref_clock_source.sv
// Purpose: reference clock sources on the two reference pairs
// Assumes: each source toggles on the core clock at its own half period
// Notes: a stopped source holds its last level, like a dead oscillator
`timescale 1ns/10ps
module ref_clock_source #(
  parameter HALF_FIRST = 4,
  parameter HALF_SECOND = 5
) (
  // clock
  input wire i_core_clk,
  // run controls
  input wire i_run_first,
  input wire i_run_second,
  // reference clocks
  output reg o_ref_first = 1'b0,
  output reg o_ref_second = 1'b0
);
  integer cnt_first = 0;
  integer cnt_second = 0;
  always @(posedge i_core_clk)
  begin
    if (i_run_first)
      cnt_first <= (cnt_first == HALF_FIRST - 1) ? 0 : cnt_first + 1;
    if (i_run_first && cnt_first == HALF_FIRST - 1)
      o_ref_first <= ~o_ref_first;
    if (i_run_second)
      cnt_second <= (cnt_second == HALF_SECOND - 1) ? 0 : cnt_second + 1;
    if (i_run_second && cnt_second == HALF_SECOND - 1)
      o_ref_second <= ~o_ref_second;
  end
endmodule // ref_clock_source

//--- verification/clock_output_control_props.sv
// Purpose: port-level checks of clock_output_control
// Assumes: bank 0 half periods are at least three core cycles
// Notes: bound to every instance of the design
`timescale 1ns/10ps
module clock_output_control_props #(
  parameter NUM_BANKS = 10
) (
  // clock and reset
  input wire i_core_clk,
  input wire i_reset,
  // pins
  input wire i_global_tristate_in,
  input wire i_counter_reset,
  input wire i_pll_bypass,
  input wire [NUM_BANKS-1:0] o_bank_a,
  input wire [NUM_BANKS-1:0] o_bank_a_oe,
  input wire [NUM_BANKS-1:0] o_bank_b_oe,
  input wire o_lock_n,
  // bus
  input wire i_s_axi_awvalid,
  input wire o_s_axi_awready,
  input wire i_s_axi_wvalid,
  input wire o_s_axi_wready,
  input wire o_s_axi_bvalid,
  input wire i_s_axi_arvalid,
  input wire o_s_axi_arready,
  input wire o_s_axi_rvalid
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_reset);
  tristate_hiz_a: assert property (
    i_global_tristate_in [*4] |=> o_bank_a_oe == '0 && o_bank_b_oe == '0)
    else $error("outputs driven in tristate");
  tristate_unlock_a: assert property (
    i_global_tristate_in [*5] |=> o_lock_n)
    else $error("lock kept in tristate");
  counter_clear_a: assert property (
    i_counter_reset [*5] |=> o_lock_n && o_bank_a == '0 && o_bank_a_oe == '0)
    else $error("counter reset not applied");
  bypass_unlock_a: assert property (
    i_pll_bypass [*5] |=> o_lock_n)
    else $error("lock shown in bypass");
  no_short_high_a: assert property (
    $rose(o_bank_a[0]) |=> (o_bank_a[0] || i_counter_reset) [*2])
    else $error("short high pulse");
  no_short_low_a: assert property (
    $fell(o_bank_a[0]) |=> (!o_bank_a[0] || i_counter_reset) [*2])
    else $error("short low pulse");
  write_answer_a: assert property (
    i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready
    |-> ##2 o_s_axi_bvalid)
    else $error("write answer late");
  read_answer_a: assert property (
    i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
    else $error("read answer late");
  write_busy_a: assert property (
    o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
    else $error("write taken during response");
  read_busy_a: assert property (
    o_s_axi_rvalid |-> !o_s_axi_arready)
    else $error("read taken during response");
endmodule // clock_output_control_props

bind clock_output_control clock_output_control_props #(.NUM_BANKS(NUM_BANKS)) i_props (
  .i_core_clk, .i_reset, .i_global_tristate_in, .i_counter_reset, .i_pll_bypass,
  .o_bank_a, .o_bank_a_oe, .o_bank_b_oe, .o_lock_n, .i_s_axi_awvalid, .o_s_axi_awready,
  .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bvalid, .i_s_axi_arvalid, .o_s_axi_arready,
  .o_s_axi_rvalid
);

//--- verification/clock_output_control_tb.sv
// Purpose: self-checking bench of clock_output_control
// Assumes: small lock and timeout counts, default dividers on bank 0
// Notes: each task under scenarios is one scenario and reports as it ends
`timescale 1ns/10ps
`include "clock_output_control_map.vh"
`define CK(g, e, m) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value at %0t: %s", $time, m); end end
module clock_output_control_tb;
  localparam NB = 4;
  localparam RT = 64;
  localparam HF = 4;
  localparam OK = `COC_RESP_OKAY;
  localparam VH = (`COC_VCO_HALF_RESET + 1) * (`COC_OUT_DIV_RESET + 1);
  localparam DH = (`COC_VCO_HALF_RESET + 1) * 4;
  localparam BH = 4 * HF;
  reg i_core_clk, i_reset, i_ref_pair_select, i_sync_gate_in, i_out_en_first;
  reg i_out_en_second, i_global_tristate_in, i_profile_sel_lsb, i_profile_sel_msb;
  reg i_pll_bypass, i_counter_reset, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready;
  reg i_s_axi_arvalid, i_s_axi_rready, run_first, run_second;
  reg [11:0] i_s_axi_awaddr, i_s_axi_araddr;
  reg [31:0] i_s_axi_wdata;
  reg [3:0] i_s_axi_wstrb;
  wire i_ref_pair_first, i_ref_pair_second, o_lock_n, o_irq, o_s_axi_awready;
  wire o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
  wire [NB-1:0] o_bank_a, o_bank_a_oe, o_bank_b, o_bank_b_oe;
  wire [1:0] o_s_axi_bresp, o_s_axi_rresp;
  wire [31:0] o_s_axi_rdata;
  integer n_mismatch = 0;
  integer compares = 0;
  integer cycles = 0;
  clock_output_control #(.NUM_BANKS(NB), .LOCK_TICKS(4), .REF_TIMEOUT(RT)) i_dut (
    .i_core_clk, .i_reset, .i_ref_pair_first, .i_ref_pair_second, .i_ref_pair_select,
    .i_sync_gate_in, .i_out_en_first, .i_out_en_second, .i_global_tristate_in,
    .i_profile_sel_lsb, .i_profile_sel_msb, .i_pll_bypass, .i_counter_reset,
    .o_bank_a, .o_bank_a_oe, .o_bank_b, .o_bank_b_oe, .o_lock_n, .o_irq,
    .i_s_axi_awaddr, .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wdata, .i_s_axi_wstrb,
    .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready,
    .i_s_axi_araddr, .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rresp,
    .o_s_axi_rvalid, .i_s_axi_rready
  );
  ref_clock_source #(.HALF_FIRST(HF), .HALF_SECOND(5)) i_refs (
    .i_core_clk, .i_run_first(run_first), .i_run_second(run_second),
    .o_ref_first(i_ref_pair_first), .o_ref_second(i_ref_pair_second)
  );
  // ****************
  // bus and helpers
  // ****************
  task cy(input integer n);
    repeat (n) @(posedge i_core_clk);
  endtask
  task wr(input [11:0] a, input [31:0] d, input [1:0] r);
    reg pa, pw;
    begin
      i_s_axi_awaddr <= a;
      i_s_axi_wdata <= d;
      i_s_axi_awvalid <= 1'b1;
      i_s_axi_wvalid <= 1'b1;
      pa = 1'b1;
      pw = 1'b1;
      while (pa || pw)
      begin
        @(posedge i_core_clk);
        if (pa && o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
        if (pa && o_s_axi_awready) pa = 1'b0;
        if (pw && o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
        if (pw && o_s_axi_wready) pw = 1'b0;
      end
      while (o_s_axi_bvalid !== 1'b1) @(posedge i_core_clk);
      `CK(o_s_axi_bresp, r, "bresp")
    end
  endtask
  task rd(input [11:0] a, output [31:0] d, input [1:0] r);
    begin
      i_s_axi_araddr <= a;
      i_s_axi_arvalid <= 1'b1;
      @(posedge i_core_clk);
      while (o_s_axi_arready !== 1'b1) @(posedge i_core_clk);
      i_s_axi_arvalid <= 1'b0;
      @(posedge i_core_clk);
      while (o_s_axi_rvalid !== 1'b1) @(posedge i_core_clk);
      d = o_s_axi_rdata;
      `CK(o_s_axi_rresp, r, "rresp")
    end
  endtask
  task rc(input [11:0] a, input [31:0] e);
    reg [31:0] d;
    begin
      rd(a, d, OK);
      `CK(d, e, "register value")
    end
  endtask
  task wl(input e);
    integer n;
    begin
      n = 0;
      while (o_lock_n !== e && n < 600)
      begin
        cy(1);
        n = n + 1;
      end
      `CK(o_lock_n, e, "lock indicator")
    end
  endtask
  // high time of bank b, taken on the second pulse
  task hw(input integer b, output integer n);
    repeat (2)
    begin
      n = 0;
      while (o_bank_a[b] !== 1'b0) cy(1);
      while (o_bank_a[b] !== 1'b1) cy(1);
      while (o_bank_a[b] === 1'b1)
      begin
        cy(1);
        n = n + 1;
      end
    end
  endtask
  // ****************
  // scenarios
  // ****************
  task t_regs;
    reg [31:0] d;
    begin
      rc(`COC_VCO_HALF_OFS, `COC_VCO_HALF_RESET);
      rc(`COC_OUT_DIV_BASE, `COC_OUT_DIV_RESET);
      rc(12'h104, `COC_CFG_RESET);
      rd(12'hFFC, d, `COC_RESP_SLVERR);
      `CK(d, 32'h0, "unmapped read data")
      wr(12'hFFC, 32'h1, `COC_RESP_SLVERR);
      $display("test regs done");
    end
  endtask
  task t_lock;
    integer n;
    begin
      wr(`COC_IRQ_MASK_OFS, 32'h1, OK);
      wl(1'b0);
      rc(`COC_STATUS_OFS, 32'h1);
      `CK(o_irq, 1'b1, "irq raised")
      wr(`COC_IRQ_MASK_OFS, 32'h0, OK);
      cy(2);
      `CK(o_irq, 1'b0, "irq masked")
      wr(`COC_IRQ_MASK_OFS, 32'h1, OK);
      wr(`COC_IRQ_STATUS_OFS, 32'h1, OK);
      cy(2);
      `CK(o_irq, 1'b0, "irq cleared")
      hw(0, n);
      `CK(n, VH, "oscillator half period")
      i_pll_bypass <= 1'b1;
      wl(1'b1);
      hw(0, n);
      `CK(n, BH, "bypass half period")
      i_pll_bypass <= 1'b0;
      wl(1'b0);
      $display("test lock done");
    end
  endtask
  task t_gate;
    integer n;
    reg s;
    begin
      wr(`COC_OUT_DIV_BASE + 12'h8, 32'h3, OK);
      wr(12'h100, 32'h8, OK);
      wr(12'h104, 32'h2, OK);
      i_sync_gate_in <= 1'b0;
      cy(20);
      s = 1'b0;
      repeat (40)
      begin
        cy(1);
        s = s | o_bank_a[0] | o_bank_b[0];
      end
      `CK(s, 1'b0, "gated bank held")
      hw(1, n);
      `CK(n, DH, "ungated bank divider")
      i_sync_gate_in <= 1'b1;
      hw(0, n);
      `CK(n, VH, "gate open")
      $display("test gate done");
    end
  endtask
  task t_prof;
    integer p;
    reg [31:0] d;
    begin
      for (p = 0; p < 4; p = p + 1)
        wr(12'(264 + 64 * p), 32'(p * 16), OK);
      for (p = 0; p < 4; p = p + 1)
      begin
        {i_out_en_first, i_out_en_second} <= 2'h1;
        i_profile_sel_lsb <= p[0];
        i_profile_sel_msb <= p[1];
        cy(6);
        rd(`COC_STATUS_OFS, d, OK);
        `CK(d[3:2], p[1:0], "profile index")
        `CK(o_bank_a_oe[2], p == 0 || p == 3, "enable mode")
        `CK(o_bank_b_oe[2], 1'b1, "always on")
        {i_out_en_first, i_out_en_second} <= 2'h2;
        cy(4);
        `CK(o_bank_a_oe[2], p == 0 || p == 2, "first enable")
      end
      i_profile_sel_lsb <= 1'b0;
      i_profile_sel_msb <= 1'b0;
      $display("test profiles done");
    end
  endtask
  task t_tri;
    begin
      i_global_tristate_in <= 1'b1;
      cy(6);
      `CK(o_bank_a_oe | o_bank_b_oe, {NB{1'b0}}, "outputs released")
      wl(1'b1);
      i_global_tristate_in <= 1'b0;
      cy(6);
      `CK(o_bank_b_oe[2], 1'b1, "outputs driven")
      wl(1'b0);
      $display("test tristate done");
    end
  endtask
  task t_ref;
    begin
      i_ref_pair_select <= 1'b1;
      run_first <= 1'b0;
      cy(3 * RT);
      `CK(o_lock_n, 1'b0, "second pair keeps lock")
      rc(`COC_STATUS_OFS, 32'h3);
      run_second <= 1'b0;
      wl(1'b1);
      i_ref_pair_select <= 1'b0;
      run_first <= 1'b1;
      wl(1'b0);
      run_second <= 1'b1;
      $display("test reference done");
    end
  endtask
  task t_cnt;
    begin
      i_counter_reset <= 1'b1;
      cy(6);
      `CK(o_lock_n, 1'b1, "lock lost")
      `CK(o_bank_a | o_bank_b | o_bank_a_oe, {NB{1'b0}}, "counters cleared")
      i_counter_reset <= 1'b0;
      rc(`COC_OUT_DIV_BASE + 12'h8, 32'h3);
      wl(1'b0);
      $display("test counter reset done");
    end
  endtask
  task results;
    begin
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  always @(posedge i_core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_mismatch = n_mismatch + 1;
      results;
    end
  end
  initial
  begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  initial
  begin
    {i_ref_pair_select, i_out_en_first, i_out_en_second, i_global_tristate_in} = 4'h0;
    {i_profile_sel_lsb, i_profile_sel_msb, i_pll_bypass, i_counter_reset} = 4'h0;
    {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_arvalid} = 3'h0;
    {i_s_axi_bready, i_s_axi_rready, run_first, run_second, i_sync_gate_in} = 5'h1F;
    {i_s_axi_awaddr, i_s_axi_araddr, i_s_axi_wdata} = 56'h0;
    i_s_axi_wstrb = 4'hF;
    i_reset = 1'b1;
    cy(16);
    i_reset <= 1'b0;
    cy(1);
    t_regs;
    t_lock;
    t_gate;
    t_prof;
    t_tri;
    t_ref;
    t_cnt;
    results;
  end
endmodule // clock_output_control_tb
